// File: shared/nbag_defines.vh
// constants for the nvm block access guard
// Notes on behaviour
// R1 - block n sits at byte n*16; blocks 0-26 user, 27-29 configuration.
// R2 - block 30 holds identity parameters, block 31 the flag and setup bytes.
// R3 - flags restrict only memory access commands in rf communication mode.
// R4 - plaintext: both flags 0 read/write; lockout only denies; read-only reads.
// R5 - encrypted: read/write always, except read-only set, lockout clear: read.
// R6 - read-only bit k of each flag byte maps to block 8*byte+k, blocks 0-26.
// R7 - reserved bits 7 to 3 of the fourth flag byte are written as zero.
// R8 - all flags reset to zero, so every block starts fully accessible.
// R9 - the memory is 32 blocks of 16 bytes, checked by block number.
// R10 - lockout flags at 0x1f8-0x1fb, same bit to block mapping as read-only.
// R11 - refused commands never write the block and report an error instead.
`ifndef NBAG_DEFINES_VH
`define NBAG_DEFINES_VH

// register indices as printed; byte address is four times the index
`define NBAG_IDX_RO0 10'h1f0
`define NBAG_IDX_RO1 10'h1f1
`define NBAG_IDX_RO2 10'h1f2
`define NBAG_IDX_RO3 10'h1f3
`define NBAG_IDX_LO0 10'h1f8
`define NBAG_IDX_LO1 10'h1f9
`define NBAG_IDX_LO2 10'h1fa
`define NBAG_IDX_LO3 10'h1fb
`define NBAG_IDX_STAT 10'h200
`define NBAG_IDX_CNT 10'h201

// flag reset values and writable bits of the last flag byte
`define NBAG_FLAG_RST 8'h00
`define NBAG_LAST_MASK 8'h07

// block map
`define NBAG_BLOCK_SHIFT 4
`define NBAG_LAST_USER 5'd26
`define NBAG_LAST_CONFIG 5'd29
`define NBAG_ID_BLOCK 5'd30
`define NBAG_FLAG_BLOCK 5'd31
`define NBAG_FLAGGED_BLOCKS 5'd27

// area codes
`define NBAG_AREA_USER 2'h0
`define NBAG_AREA_CONFIG 2'h1
`define NBAG_AREA_IDENT 2'h2
`define NBAG_AREA_SETUP 2'h3

// status register fields
`define NBAG_STAT_BLK_LSB 0
`define NBAG_STAT_ALLOW_BIT 8
`define NBAG_STAT_WR_BIT 9
`define NBAG_STAT_ENC_BIT 10
`define NBAG_STAT_AREA_LSB 12
`define NBAG_STAT_VALID_BIT 15

`endif

// File: hdl/nbag_guard.v
// nvm block access guard: per-block rf access check with apb flag registers
//
// The implementer's own choice: the APB register port.
`include "nbag_defines.vh"
`default_nettype none

module nbag_guard #(
  parameter ADDR_W = 9,
  parameter CNT_W = 16
) (
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // access request from the command processor
  input wire cmd_valid,
  input wire cmd_write,
  input wire cmd_encrypted,
  input wire cmd_rf_mode,
  input wire [ADDR_W-1:0] cmd_addr,
  // decision, one cycle after the request
  output reg chk_done,
  output reg chk_allow,
  output reg chk_error,
  output reg [1:0] chk_area,
  output reg [4:0] chk_block,
  output reg nvm_rd_en,
  output reg nvm_wr_en,
  // flag images for the rest of the tag
  output wire [26:0] ro_flags,
  output wire [26:0] lo_flags
);

  // flag storage, reset to all zero so every block starts open
  reg [7:0] ro0_reg;
  reg [7:0] ro1_reg;
  reg [7:0] ro2_reg;
  reg [7:0] ro3_reg;
  reg [7:0] lo0_reg;
  reg [7:0] lo1_reg;
  reg [7:0] lo2_reg;
  reg [7:0] lo3_reg;

  // last decision kept for software
  reg [4:0] last_blk_reg;
  reg last_allow_reg;
  reg last_wr_reg;
  reg last_enc_reg;
  reg [1:0] last_area_reg;
  reg last_valid_reg;
  reg [CNT_W-1:0] deny_cnt_reg;
  reg [CNT_W-1:0] deny_cnt_next;

  // bus decode: word index is the byte address over four
  wire [9:0] word_idx;
  wire setup_ph;
  wire wr_acc;
  reg mapped;
  reg [31:0] rd_mux;

  assign word_idx = paddr[11:2];
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  // zero wait states: the access phase always completes at once
  assign pready = 1'b1;

  // flags pack into block order: bit k of byte j is block 8*j+k
  assign ro_flags = {ro3_reg[2:0], ro2_reg, ro1_reg, ro0_reg}; // [R6]
  assign lo_flags = {lo3_reg[2:0], lo2_reg, lo1_reg, lo0_reg}; // [R10]

  // address decode and read data selection
  always @* begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (word_idx)
      `NBAG_IDX_RO0: rd_mux = {24'h000000, ro0_reg};
      `NBAG_IDX_RO1: rd_mux = {24'h000000, ro1_reg};
      `NBAG_IDX_RO2: rd_mux = {24'h000000, ro2_reg};
      `NBAG_IDX_RO3: rd_mux = {24'h000000, ro3_reg};
      `NBAG_IDX_LO0: rd_mux = {24'h000000, lo0_reg};
      `NBAG_IDX_LO1: rd_mux = {24'h000000, lo1_reg};
      `NBAG_IDX_LO2: rd_mux = {24'h000000, lo2_reg};
      `NBAG_IDX_LO3: rd_mux = {24'h000000, lo3_reg};
      `NBAG_IDX_STAT: begin
        rd_mux[`NBAG_STAT_BLK_LSB +: 5] = last_blk_reg;
        rd_mux[`NBAG_STAT_ALLOW_BIT] = last_allow_reg;
        rd_mux[`NBAG_STAT_WR_BIT] = last_wr_reg;
        rd_mux[`NBAG_STAT_ENC_BIT] = last_enc_reg;
        rd_mux[`NBAG_STAT_AREA_LSB +: 2] = last_area_reg;
        rd_mux[`NBAG_STAT_VALID_BIT] = last_valid_reg;
      end
      `NBAG_IDX_CNT: rd_mux[CNT_W-1:0] = deny_cnt_reg;
      default: mapped = 1'b0;
    endcase
  end

  // read data and error are registered in the setup cycle so they
  // already stand from flops when the access phase is sampled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~mapped;
    end else if (!psel) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // flag writes land at the access edge, byte lane 0 only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ro0_reg <= `NBAG_FLAG_RST; // [R8]
      ro1_reg <= `NBAG_FLAG_RST; // [R8]
      ro2_reg <= `NBAG_FLAG_RST; // [R8]
      ro3_reg <= `NBAG_FLAG_RST; // [R8]
      lo0_reg <= `NBAG_FLAG_RST; // [R8]
      lo1_reg <= `NBAG_FLAG_RST; // [R8]
      lo2_reg <= `NBAG_FLAG_RST; // [R8]
      lo3_reg <= `NBAG_FLAG_RST; // [R8]
    end else if (wr_acc && pstrb[0]) begin
      case (word_idx)
        `NBAG_IDX_RO0: ro0_reg <= pwdata[7:0];
        `NBAG_IDX_RO1: ro1_reg <= pwdata[7:0];
        `NBAG_IDX_RO2: ro2_reg <= pwdata[7:0];
        // reserved bits are forced to zero whatever software sends
        `NBAG_IDX_RO3: ro3_reg <= pwdata[7:0] & `NBAG_LAST_MASK; // [R7]
        `NBAG_IDX_LO0: lo0_reg <= pwdata[7:0];
        `NBAG_IDX_LO1: lo1_reg <= pwdata[7:0];
        `NBAG_IDX_LO2: lo2_reg <= pwdata[7:0];
        `NBAG_IDX_LO3: lo3_reg <= pwdata[7:0] & `NBAG_LAST_MASK; // [R7]
        default: ro0_reg <= ro0_reg;
      endcase
    end
  end

  // block number is the byte address over sixteen
  wire [4:0] req_blk;
  assign req_blk = cmd_addr[ADDR_W-1:`NBAG_BLOCK_SHIFT]; // [R1] [R9]

  // area classification of the addressed block
  reg [1:0] req_area;
  always @* begin
    if (req_blk <= `NBAG_LAST_USER) begin
      req_area = `NBAG_AREA_USER; // [R1]
    end else if (req_blk <= `NBAG_LAST_CONFIG) begin
      req_area = `NBAG_AREA_CONFIG; // [R1]
    end else if (req_blk == `NBAG_ID_BLOCK) begin
      req_area = `NBAG_AREA_IDENT; // [R2]
    end else begin
      req_area = `NBAG_AREA_SETUP; // [R2]
    end
  end

  // flags of the addressed block; blocks above 26 carry none
  reg blk_ro;
  reg blk_lo;
  always @* begin
    blk_ro = 1'b0;
    blk_lo = 1'b0;
    if (req_blk < `NBAG_FLAGGED_BLOCKS) begin
      blk_ro = ro_flags[req_blk]; // [R6]
      blk_lo = lo_flags[req_blk]; // [R10]
    end
  end

  // permission table; outside rf mode nothing is restricted
  reg may_read;
  reg may_write;
  always @* begin
    may_read = 1'b1;
    may_write = 1'b1;
    if (!cmd_rf_mode) begin
      may_read = 1'b1; // [R3]
      may_write = 1'b1; // [R3]
    end else if (cmd_encrypted) begin
      // only read-only without lockout still blocks an encrypted write
      may_read = 1'b1; // [R5]
      may_write = ~(blk_ro & ~blk_lo); // [R5]
    end else begin
      // plaintext: lockout alone shuts the block, read-only keeps reads
      may_read = blk_ro | ~blk_lo; // [R4]
      may_write = ~blk_ro & ~blk_lo; // [R4]
    end
  end

  wire req_ok;
  assign req_ok = cmd_write ? may_write : may_read;

  // registered decision; the memory strobes fire only when allowed,
  // so a refused write cannot reach the array
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_done <= 1'b0;
      chk_allow <= 1'b0;
      chk_error <= 1'b0;
      chk_area <= `NBAG_AREA_USER;
      chk_block <= 5'h00;
      nvm_rd_en <= 1'b0;
      nvm_wr_en <= 1'b0;
    end else begin
      chk_done <= cmd_valid;
      chk_allow <= cmd_valid & req_ok;
      chk_error <= cmd_valid & ~req_ok; // [R11]
      nvm_rd_en <= cmd_valid & ~cmd_write & req_ok;
      nvm_wr_en <= cmd_valid & cmd_write & req_ok; // [R11]
      if (cmd_valid) begin
        chk_area <= req_area;
        chk_block <= req_blk;
      end
    end
  end

  // refusal counter: saturates, and a fresh refusal beats a clear
  wire cnt_clr;
  assign cnt_clr = wr_acc && pstrb[0] && (word_idx == `NBAG_IDX_CNT);
  always @* begin
    deny_cnt_next = deny_cnt_reg;
    if (cnt_clr) begin
      deny_cnt_next = {CNT_W{1'b0}};
    end
    if (cmd_valid && !req_ok) begin
      if (cnt_clr) begin
        deny_cnt_next = {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (deny_cnt_reg != {CNT_W{1'b1}}) begin
        deny_cnt_next = deny_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // snapshot of the latest request for the status register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_blk_reg <= 5'h00;
      last_allow_reg <= 1'b0;
      last_wr_reg <= 1'b0;
      last_enc_reg <= 1'b0;
      last_area_reg <= `NBAG_AREA_USER;
      last_valid_reg <= 1'b0;
      deny_cnt_reg <= {CNT_W{1'b0}};
    end else begin
      deny_cnt_reg <= deny_cnt_next;
      if (cmd_valid) begin
        last_blk_reg <= req_blk;
        last_allow_reg <= req_ok;
        last_wr_reg <= cmd_write;
        last_enc_reg <= cmd_encrypted;
        last_area_reg <= req_area;
        last_valid_reg <= 1'b1;
      end
    end
  end

endmodule // nbag_guard

`default_nettype wire

// File: bench/nbag_reader.sv
// rf reader model issuing memory access commands
`default_nettype none
module nbag_reader (
  input wire logic pclk,
  input wire logic go,
  input wire logic [2:0] op,
  input wire logic [8:0] addr,
  output logic cmd_valid = 1'b0,
  output logic cmd_write = 1'b0,
  output logic cmd_encrypted = 1'b0,
  output logic cmd_rf_mode = 1'b0,
  output logic [8:0] cmd_addr = 9'h000
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle address toggles and idle qualifiers hold the inverse of op, stale values must never look valid
  always @(posedge pclk) begin
    cmd_valid <= go;
    cmd_addr <= go ? addr : ~cmd_addr;
    {cmd_rf_mode, cmd_encrypted, cmd_write} <= go ? op : ~op;
  end
endmodule // nbag_reader
`default_nettype wire

// File: bench/nbag_guard_sva.sv
// assertions for the nvm block access guard
`default_nettype none
module nbag_guard_sva #(
  parameter ADDR_W = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_encrypted,
  input wire logic cmd_rf_mode,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic chk_done,
  input wire logic chk_allow,
  input wire logic chk_error,
  input wire logic [1:0] chk_area,
  input wire logic [4:0] chk_block,
  input wire logic nvm_rd_en,
  input wire logic nvm_wr_en,
  input wire logic [26:0] ro_flags,
  input wire logic [26:0] lo_flags
);
  timeunit 1ns;
  timeprecision 100ps;
  // flags of the addressed block; blocks above 26 carry none
  wire [4:0] blk = cmd_addr[ADDR_W-1:4];
  wire ro_b = (blk < 5'd27) ? ro_flags[blk] : 1'b0;
  wire lo_b = (blk < 5'd27) ? lo_flags[blk] : 1'b0;
  wire pl_ok = cmd_write ? (!ro_b && !lo_b) : (ro_b || !lo_b);
  wire en_ok = !cmd_write || !(ro_b && !lo_b);
  wire rf_pl = cmd_valid && cmd_rf_mode && !cmd_encrypted;
  wire rf_en = cmd_valid && cmd_rf_mode && cmd_encrypted;
  wire [1:0] ar = (blk < 5'd27) ? 2'h0 : (blk < 5'd30) ? 2'h1 : {1'b1, blk[0]};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  done_follow_a: assert property (cmd_valid |=> chk_done)
    else $error("no decision after request");
  done_quiet_a: assert property (!cmd_valid |=> !chk_done)
    else $error("decision without request");
  one_verdict_a: assert property (chk_done |-> chk_allow ^ chk_error)
    else $error("verdict not exclusive");
  refused_idle_a: assert property (chk_error |-> !nvm_wr_en && !nvm_rd_en)
    else $error("refused access reached memory");
  enable_dir_a: assert property (cmd_valid |=> nvm_wr_en == (chk_allow && $past(cmd_write)))
    else $error("write enable wrong");
  block_area_a: assert property (cmd_valid |=> chk_block == $past(blk) && chk_area == $past(ar))
    else $error("block or area wrong");
  free_path_a: assert property (cmd_valid && !cmd_rf_mode |=> chk_allow)
    else $error("non rf access refused");
  plain_rule_a: assert property (rf_pl |=> chk_allow == $past(pl_ok))
    else $error("plaintext decision wrong");
  enc_rule_a: assert property (rf_en |=> chk_allow == $past(en_ok))
    else $error("encrypted decision wrong");
  cover property (rf_pl ##1 chk_error);
  cover property (rf_en && ro_b && lo_b && cmd_write ##1 chk_allow);
  cover property (rf_pl && ro_b && !cmd_write ##1 nvm_rd_en);
endmodule // nbag_guard_sva
bind nbag_guard nbag_guard_sva #(.ADDR_W(ADDR_W)) nbag_guard_sva_i (
  .pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .cmd_encrypted(cmd_encrypted),
  .cmd_rf_mode(cmd_rf_mode), .cmd_addr(cmd_addr), .chk_done(chk_done),
  .chk_allow(chk_allow), .chk_error(chk_error), .chk_area(chk_area),
  .chk_block(chk_block), .nvm_rd_en(nvm_rd_en), .nvm_wr_en(nvm_wr_en),
  .ro_flags(ro_flags), .lo_flags(lo_flags));
`default_nettype wire

// File: bench/nbag_guard_test.sv
// self-checking bench for the nvm block access guard
`include "nbag_defines.vh"
`default_nettype none
module nbag_guard_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, go = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, ro_m = 32'h0, lo_m = 32'h0;
  logic [31:0] st_m = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [2:0] op = 3'h0, o;
  logic [8:0] addr = 9'h000, cmd_addr;
  logic [7:0] v;
  wire pready, pslverr, cmd_valid, cmd_write, cmd_encrypted, cmd_rf_mode;
  wire chk_done, chk_allow, chk_error, nvm_rd_en, nvm_wr_en;
  wire [31:0] prdata;
  wire [1:0] chk_area;
  wire [4:0] chk_block;
  wire [26:0] ro_flags, lo_flags;
  int seed = 70, n_fail = 0, total_checks = 0, n_den = 0;
  always #50 pclk = ~pclk;
  nbag_guard nbag_guard_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_encrypted(cmd_encrypted), .cmd_rf_mode(cmd_rf_mode),
    .chk_done(chk_done), .chk_allow(chk_allow), .chk_error(chk_error),
    .chk_area(chk_area), .chk_block(chk_block), .nvm_rd_en(nvm_rd_en),
    .nvm_wr_en(nvm_wr_en), .ro_flags(ro_flags), .lo_flags(lo_flags));
  nbag_reader nbag_reader_i (.pclk(pclk), .go(go), .op(op), .addr(addr),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_encrypted(cmd_encrypted), .cmd_rf_mode(cmd_rf_mode));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // byte address of register i: read-only, lockout, then status and count
  function automatic logic [11:0] fa(int i);
    int x;
    x = i < 4 ? `NBAG_IDX_RO0 + i : i < 8 ? `NBAG_IDX_LO0 + i - 4
      : `NBAG_IDX_STAT + i - 8;
    return 12'(x << 2);
  endfunction
  // expected area code of a block
  function automatic logic [1:0] ar_of(logic [4:0] b);
    if (b <= 5'd26) return 2'h0;
    if (b <= 5'd29) return 2'h1;
    return (b == 5'd30) ? 2'h2 : 2'h3;
  endfunction
  // expected permission; c is {rf, encrypted, write}
  function automatic logic ok_of(logic [2:0] c, logic [4:0] b);
    logic ro, lo;
    ro = ro_m[b];
    lo = lo_m[b];
    if (!c[2]) return 1'b1;
    if (c[1]) return !c[0] || !(ro && !lo);
    return c[0] ? (!ro && !lo) : (ro || !lo);
  endfunction
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the hang guard ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // request via the reader, verdict sampled once settled
  task automatic cmd(input logic [2:0] c, input logic [8:0] a);
    logic k;
    logic [4:0] b;
    b = a[8:4];
    k = ok_of(c, b);
    go <= 1'b1;
    op <= c;
    addr <= a;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk({chk_done, chk_allow, chk_error, nvm_wr_en, nvm_rd_en, chk_area,
      chk_block}, {1'b1, k, !k, k && c[0], k && !c[0], ar_of(b),
      b});
    if (!k) n_den++;
    st_m = {16'h0, 1'b1, 1'b0, ar_of(b), 1'b0, c[1], c[0], k, 3'h0, b};
    @(posedge pclk);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // flags clear after reset, every mode open
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, fa(i), 32'h0, rd, er);
      chk(rd, 32'h0);
      cmd(3'(i), 9'(i * 61));
    end
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    // random flags; reserved bits of the last byte kept at zero
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      if (i % 4 == 3) v = v & 8'h07;
      apb(1'b1, fa(i), {24'h0, v}, rd, er);
      apb(1'b0, fa(i), 32'h0, rd, er);
      chk(rd, {24'h0, v});
      if (i < 4) ro_m[8 * i +: 8] = v;
      else lo_m[8 * (i - 4) +: 8] = v;
    end
    chk({5'h0, ro_flags}, ro_m);
    chk({5'h0, lo_flags}, lo_m);
    // rf path favoured so the flags decide most requests
    repeat (150) begin
      o = 3'($random(seed));
      if (($random(seed) & 3) != 0) o[2] = 1'b1;
      cmd(o, 9'($random(seed)));
    end
    // refusal count and status of the last request
    apb(1'b0, fa(9), 32'h0, rd, er);
    chk(rd, 32'(n_den));
    apb(1'b0, fa(8), 32'h0, rd, er);
    chk(rd, st_m);
    apb(1'b1, fa(9), 32'h0, rd, er);
    apb(1'b0, fa(9), 32'h0, rd, er);
    chk(rd, 32'h0);
    // mid-run reset must clear every flag and the status
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({5'h0, ro_flags}, 32'h0);
    chk({5'h0, lo_flags}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    ro_m = 32'h0;
    lo_m = 32'h0;
    apb(1'b0, fa(8), 32'h0, rd, er);
    chk(rd, 32'h0);
    cmd(3'h4, 9'h0a5);
    final_report();
  end
  // hang guard, far beyond the planned run
  initial begin
    #(100 * 20000);
    n_fail++;
    final_report();
  end
endmodule // nbag_guard_test
`default_nettype wire
